// ### inc/hvm_pkg.sv
/*
 * Constants and types for the halfword vector multiplier datapath.
 * Assumes a 32-bit general register width and a 32-bit DSP control word.
 */
package hvm_pkg;

	// ****************************************************************
	// Operation select
	// ****************************************************************
	typedef enum logic [3:0]
	{
		HVM_OP_MUL_WRAP = 4'h1,
		HVM_OP_MUL_SAT  = 4'h2,
		HVM_OP_FRAC_L   = 4'h4,
		HVM_OP_FRAC_R   = 4'h8
	} hvm_op_e;

	// ****************************************************************
	// Pipeline stage states
	// ****************************************************************
	typedef enum logic [1:0]
	{
		HVM_ST_IDLE = 2'h1,
		HVM_ST_WB   = 2'h2
	} hvm_state_e;

	// ****************************************************************
	// Widths, fields and limits
	// ****************************************************************
	localparam int          HVM_WORD_W      = 32;
	localparam int          HVM_HALF_W      = 16;
	localparam int          HVM_ACC_W       = 64;
	localparam int          HVM_OUFLAG_BIT  = 21;
	localparam int          HVM_UPPER_LSB   = 16;
	localparam logic [15:0] HVM_HALF_MAX    = 16'h7fff;
	localparam logic [15:0] HVM_HALF_MIN    = 16'h8000;
	localparam logic [31:0] HVM_PROD_MAX    = 32'h00007fff;
	localparam logic [31:0] HVM_PROD_MIN    = 32'hffff8000;
	localparam logic [31:0] HVM_Q31_MAX     = 32'h7fffffff;
	localparam logic [31:0] HVM_DSPCTL_RST  = 32'h00000000;
	localparam logic [63:0] HVM_ACC_RST     = 64'h0000000000000000;
	localparam logic [31:0] HVM_WORD_ZERO   = 32'h00000000;

endpackage : hvm_pkg

// ### hw/hvm_lane_mul.sv
/*
 * One signed 16 x 16 lane multiplier with wrap and saturate results.
 * Assumes a combinational use inside a single-clock datapath.
 */
`timescale 1ns/1ns
module hvm_lane_mul
	import hvm_pkg::*;
(
	input  wire logic [15:0] lane_a,
	input  wire logic [15:0] lane_b,
	output logic      [15:0] wrap_result,
	output logic      [15:0] sat_result,
	output logic             range_out
);

	logic signed [31:0] product;
	logic               above_max;
	logic               below_min;

	always_comb
	begin
		product     = $signed(lane_a) * $signed(lane_b);
		above_max   = product > $signed(HVM_PROD_MAX);
		below_min   = product < $signed(HVM_PROD_MIN);
		range_out   = above_max | below_min;
		wrap_result = product[15:0];
		if (above_max)
		begin
			sat_result = HVM_HALF_MAX;
		end
		else if (below_min)
		begin
			sat_result = HVM_HALF_MIN;
		end
		else
		begin
			sat_result = product[15:0];
		end
	end

endmodule : hvm_lane_mul

// ### hw/hvm_frac_mul.sv
/*
 * Q15 x Q15 to Q31 fractional multiplier with the single clamp case.
 * Assumes a combinational use inside a single-clock datapath.
 */
`timescale 1ns/1ns
module hvm_frac_mul
	import hvm_pkg::*;
(
	input  wire logic [15:0] frac_a,
	input  wire logic [15:0] frac_b,
	output logic      [31:0] q31_result,
	output logic             clamped
);

	logic signed [31:0] product;

	always_comb
	begin
		product = $signed(frac_a) * $signed(frac_b);
		clamped = (frac_a == HVM_HALF_MIN) && (frac_b == HVM_HALF_MIN);
		if (clamped)
		begin
			q31_result = HVM_Q31_MAX;
		end
		else
		begin
			q31_result = {product[30:0], 1'b0};
		end
	end

endmodule : hvm_frac_mul

// ### hw/hvm_halfword_vector_multiplier.sv
/*
 * Halfword vector multiplier: two packed lane multiplies (wrap, saturate)
 * and two Q15 to Q31 widening multiplies, with result and control-flag
 * update delivered together one clock after issue.
 * Assumes the pipeline decodes the instruction, presents operands with a
 * one-cycle issue pulse, and handles the two non-data exceptions that are
 * decoded here from the enable straps and reported one clock after issue.
 */
// Notes on behaviour
// - Signed lane products are full 32-bit.
// - Wrap form keeps low 16 bits per lane.
// - Saturate form clips lanes to 0x7fff/0x8000.
// - Saturate overflow sets control bit 21.
// - Wrap form also sets bit 21 on overflow.
// - Left form multiplies upper halfwords to Q31.
// - Right form multiplies lower halfwords to Q31.
// - Both inputs 0x8000 give 0x7fffffff.
// - Clamped fraction result sets bit 21.
// - Accumulator zero left undefined after these.
// - Extra accumulators are never modified.
// - No operand-dependent exceptions are raised.
// - Only reserved and disabled exceptions exist.
`timescale 1ns/1ns
module hvm_halfword_vector_multiplier
	import hvm_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        issue_valid,
	input  wire logic [3:0]  issue_op,
	input  wire logic [31:0] source_a,
	input  wire logic [31:0] source_b,
	input  wire logic        extension_present,
	input  wire logic        extension_enabled,
	input  wire logic [31:0] dsp_control_in,
	input  wire logic [63:0] accumulator_zero_in,
	output logic             wb_valid,
	output logic      [31:0] wb_dest,
	output logic             wb_control_write,
	output logic      [31:0] wb_dsp_control,
	output logic             wb_acc_zero_write,
	output logic      [63:0] wb_accumulator_zero,
	output logic             exc_reserved_instruction,
	output logic             exc_extension_disabled
);

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	function automatic logic op_is_known(input logic [3:0] op);
		logic known;
		known = (op == HVM_OP_MUL_WRAP) || (op == HVM_OP_MUL_SAT)
			|| (op == HVM_OP_FRAC_L) || (op == HVM_OP_FRAC_R);
		return known;
	endfunction : op_is_known

	function automatic logic op_is_left(input logic [3:0] op);
		logic left;
		left = (op == HVM_OP_FRAC_L);
		return left;
	endfunction : op_is_left

	// ****************************************************************
	// Lane and fraction multipliers
	// ****************************************************************
	logic [15:0] hi_wrap;
	logic [15:0] hi_sat;
	logic        hi_range;
	logic [15:0] lo_wrap;
	logic [15:0] lo_sat;
	logic        lo_range;
	logic [15:0] frac_sel_a;
	logic [15:0] frac_sel_b;
	logic [31:0] frac_result;
	logic        frac_clamped;

	// Index 1 is the upper lane (bits 31..16), index 0 the lower lane
	logic [15:0] lane_wrap  [2];
	logic [15:0] lane_sat   [2];
	logic        lane_range [2];

	genvar lane_idx;
	generate
		for (lane_idx = 0; lane_idx < 2; lane_idx++)
		begin : gen_lane
			hvm_lane_mul hvm_lane_mul_inst
			(
				.lane_a      (source_a[lane_idx*HVM_HALF_W +: HVM_HALF_W]),
				.lane_b      (source_b[lane_idx*HVM_HALF_W +: HVM_HALF_W]),
				.wrap_result (lane_wrap[lane_idx]),
				.sat_result  (lane_sat[lane_idx]),
				.range_out   (lane_range[lane_idx])
			);
		end
	endgenerate

	always_comb
	begin
		hi_wrap  = lane_wrap[1];
		hi_sat   = lane_sat[1];
		hi_range = lane_range[1];
		lo_wrap  = lane_wrap[0];
		lo_sat   = lane_sat[0];
		lo_range = lane_range[0];
	end

	always_comb
	begin
		if (op_is_left(issue_op))
		begin
			frac_sel_a = source_a[31:16];
			frac_sel_b = source_b[31:16];
		end
		else
		begin
			frac_sel_a = source_a[15:0];
			frac_sel_b = source_b[15:0];
		end
	end

	hvm_frac_mul u_frac
	(
		.frac_a     (frac_sel_a),
		.frac_b     (frac_sel_b),
		.q31_result (frac_result),
		.clamped    (frac_clamped)
	);

	// ****************************************************************
	// Issue decode and result select
	// ****************************************************************
	logic [31:0] dest_value;
	logic        flag_event;

	always_comb
	begin
		dest_value = HVM_WORD_ZERO;
		flag_event = 1'b0;
		case (issue_op)
			HVM_OP_MUL_WRAP:
			begin
				dest_value = {hi_wrap, lo_wrap};
				flag_event = hi_range | lo_range;
			end
			HVM_OP_MUL_SAT:
			begin
				dest_value = {hi_sat, lo_sat};
				flag_event = hi_range | lo_range;
			end
			HVM_OP_FRAC_L, HVM_OP_FRAC_R:
			begin
				dest_value = frac_result;
				flag_event = frac_clamped;
			end
			default:
			begin
				dest_value = HVM_WORD_ZERO;
				flag_event = 1'b0;
			end
		endcase
	end

	// ****************************************************************
	// Exception decode
	// ****************************************************************
	logic op_known;
	logic exc_ri;
	logic exc_dis;
	logic accept;

	// Exceptions depend only on the issue pulse, the opcode and the straps, never on operand values
	always_comb
	begin
		op_known = op_is_known(issue_op);
		exc_ri   = issue_valid && op_known && !extension_present;
		exc_dis  = issue_valid && op_known && extension_present && !extension_enabled;
		accept   = issue_valid && op_known && extension_present && extension_enabled;
	end

	// ****************************************************************
	// Control word merge
	// ****************************************************************
	logic [31:0] merged_control;

	// Only the flag bit may change, and only from zero to one
	always_comb
	begin
		merged_control                 = dsp_control_in;
		merged_control[HVM_OUFLAG_BIT] = dsp_control_in[HVM_OUFLAG_BIT] | flag_event;
	end

	// ****************************************************************
	// Accumulator zero
	// ****************************************************************
	logic [63:0] acc_scratch;

	// The operand pair is parked in accumulator zero; its old value is lost
	always_comb
	begin
		acc_scratch = {source_a, source_b};
	end

	// ****************************************************************
	// Writeback stage
	// ****************************************************************
	hvm_state_e  state_ff;
	hvm_state_e  nxt_state;
	logic [31:0] dest_ff;
	logic [31:0] nxt_dest;
	logic [31:0] control_ff;
	logic [31:0] nxt_control;
	logic [63:0] acc_ff;
	logic [63:0] nxt_acc;
	logic        exc_ri_ff;
	logic        nxt_exc_ri;
	logic        exc_dis_ff;
	logic        nxt_exc_dis;

	always_comb
	begin
		nxt_state   = state_ff;
		nxt_dest    = dest_ff;
		nxt_control = control_ff;
		nxt_acc     = acc_ff;
		nxt_exc_ri  = exc_ri;
		nxt_exc_dis = exc_dis;
		case (state_ff)
			HVM_ST_IDLE, HVM_ST_WB:
			begin
				if (accept)
				begin
					nxt_state   = HVM_ST_WB;
					nxt_dest    = dest_value;
					nxt_control = merged_control;
					nxt_acc     = acc_scratch;
				end
				else
				begin
					nxt_state = HVM_ST_IDLE;
				end
			end
			default:
			begin
				nxt_state = HVM_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			state_ff   <= HVM_ST_IDLE;
			dest_ff    <= HVM_WORD_ZERO;
			control_ff <= HVM_DSPCTL_RST;
			acc_ff     <= HVM_ACC_RST;
			exc_ri_ff  <= 1'b0;
			exc_dis_ff <= 1'b0;
		end
		else
		begin
			state_ff   <= nxt_state;
			dest_ff    <= nxt_dest;
			control_ff <= nxt_control;
			acc_ff     <= nxt_acc;
			exc_ri_ff  <= nxt_exc_ri;
			exc_dis_ff <= nxt_exc_dis;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Extra accumulators have no port here, so they cannot be touched
	always_comb
	begin
		wb_valid                 = (state_ff == HVM_ST_WB);
		wb_control_write         = (state_ff == HVM_ST_WB);
		wb_acc_zero_write        = (state_ff == HVM_ST_WB);
		exc_reserved_instruction = exc_ri_ff;
		exc_extension_disabled   = exc_dis_ff;
	end

	// Data outputs come straight from the writeback registers
	always_comb
	begin
		wb_dest             = dest_ff;
		wb_dsp_control      = control_ff;
		wb_accumulator_zero = acc_ff;
	end

	// Accumulator zero input is only observed to document its loss
	logic unused_acc;
	always_comb
	begin
		unused_acc = ^accumulator_zero_in;
	end

endmodule : hvm_halfword_vector_multiplier

// ### verif/hvm_halfword_vector_multiplier_asserts.sv
/* Port checker for the halfword vector multiplier.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ns
module hvm_chk_asserts
(
	input wire logic        clock,
	input wire logic        reset_n,
	input wire logic        issue_valid,
	input wire logic [3:0]  issue_op,
	input wire logic [31:0] source_a,
	input wire logic [31:0] source_b,
	input wire logic        extension_present,
	input wire logic        extension_enabled,
	input wire logic [31:0] dsp_control_in,
	input wire logic        wb_valid,
	input wire logic [31:0] wb_dest,
	input wire logic        wb_control_write,
	input wire logic [31:0] wb_dsp_control,
	input wire logic        wb_acc_zero_write,
	input wire logic        exc_reserved_instruction,
	input wire logic        exc_extension_disabled
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	logic op_ok;
	assign op_ok = issue_op inside {4'h1, 4'h2, 4'h4, 4'h8};
	sequence take_s;
		issue_valid && op_ok;
	endsequence
	sequence accept_s;
		take_s ##0 extension_present && extension_enabled;
	endsequence
	wb_pulse_a: assert property (
		wb_valid == $past(issue_valid && op_ok && extension_present && extension_enabled))
		else $error("writeback pulse misplaced");
	strobe_pair_a: assert property (
		wb_valid == wb_control_write && wb_valid == wb_acc_zero_write)
		else $error("writeback strobes split");
	ctl_keep_a: assert property (
		wb_valid |-> (wb_dsp_control | 32'h00200000) == ($past(dsp_control_in) | 32'h00200000))
		else $error("control bits changed");
	flag_sticky_a: assert property (
		wb_valid && $past(dsp_control_in[21]) |-> wb_dsp_control[21])
		else $error("flag cleared");
	frac_clamp_a: assert property (
		accept_s ##0 (issue_op == 4'h4 && source_a[31:16] == 16'h8000 && source_b[31:16] == 16'h8000)
		|=> wb_dest == 32'h7fffffff && wb_dsp_control[21])
		else $error("fraction clamp missing");
	rsv_exc_a: assert property (
		take_s ##0 !extension_present |=> exc_reserved_instruction && !wb_valid)
		else $error("reserved exception missing");
	dis_exc_a: assert property (
		take_s ##0 (extension_present && !extension_enabled)
		|=> exc_extension_disabled && !wb_valid && !exc_reserved_instruction)
		else $error("disabled exception missing");
	no_exc_a: assert property (
		accept_s |=> !exc_reserved_instruction && !exc_extension_disabled)
		else $error("operand exception raised");
endmodule : hvm_chk_asserts

bind hvm_halfword_vector_multiplier hvm_chk_asserts hvm_chk_asserts_inst (.clock, .reset_n,
	.issue_valid, .issue_op, .source_a, .source_b, .extension_present, .extension_enabled,
	.dsp_control_in, .wb_valid, .wb_dest, .wb_control_write, .wb_dsp_control,
	.wb_acc_zero_write, .exc_reserved_instruction, .exc_extension_disabled);

// ### verif/hvm_pipe_model.sv
/* Pipeline model holding the DSP control word, with writeback forwarding.
   Assumes software writes never coincide with a writeback. */
`timescale 1ns/1ns
module hvm_pipe_model
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        sw_write,
	input  wire logic [31:0] sw_data,
	input  wire logic        wb_control_write,
	input  wire logic [31:0] wb_dsp_control,
	output logic      [31:0] dsp_control_in
);
	// ****************************************************************
	// Control word
	// ****************************************************************
	logic [31:0] ctl_ff;
	logic [31:0] nxt_ctl;
	always_comb
	begin
		nxt_ctl = ctl_ff;
		if (sw_write)
			nxt_ctl = sw_data;
		else if (wb_control_write)
			nxt_ctl = wb_dsp_control;
	end
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			ctl_ff <= 32'h00000000;
		else
			ctl_ff <= nxt_ctl;
	end
	// A writeback in flight is forwarded so back-to-back issues keep the flag
	assign dsp_control_in = wb_control_write ? wb_dsp_control : ctl_ff;
endmodule : hvm_pipe_model

// ### verif/tb_halfword_vector_multiplier.sv
/* Self-checking bench for the halfword vector multiplier.
   Assumes the pipeline model and the bound port checker. */
`timescale 1ns/1ns
module tb_halfword_vector_multiplier
	import hvm_pkg::*;
;
	// ****************************************************************
	// Stimulus and checking
	// ****************************************************************
	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic        issue_valid = 1'b0;
	logic [3:0]  issue_op = 4'h0;
	logic [31:0] source_a = 32'h0;
	logic [31:0] source_b = 32'h0;
	logic [1:0]  ext = 2'h3;
	logic [63:0] acc_in = 64'h0;
	logic        sw_write = 1'b0;
	logic [31:0] sw_data = 32'h0;
	logic [31:0] ctl, exp_ctl, wb_dest, wb_ctl;
	logic        wb_valid, wb_ctl_wr, exc_r, exc_d;
	logic [66:0] e;
	logic [66:0] exp_q[$];
	integer      seed = 5914;
	integer      n_mismatch = 0;
	integer      check_count = 0;
	integer      i;
	always #4 clock = ~clock;
	hvm_halfword_vector_multiplier hvm_halfword_vector_multiplier_inst (.clock(clock),
		.reset_n(reset_n), .issue_valid(issue_valid), .issue_op(issue_op),
		.source_a(source_a), .source_b(source_b), .extension_present(ext[1]),
		.extension_enabled(ext[0]), .dsp_control_in(ctl), .accumulator_zero_in(acc_in),
		.wb_valid(wb_valid), .wb_dest(wb_dest), .wb_control_write(wb_ctl_wr),
		.wb_dsp_control(wb_ctl), .wb_acc_zero_write(), .wb_accumulator_zero(),
		.exc_reserved_instruction(exc_r), .exc_extension_disabled(exc_d));
	hvm_pipe_model hvm_pipe_model_inst (.clock(clock), .reset_n(reset_n), .sw_write(sw_write),
		.sw_data(sw_data), .wb_control_write(wb_ctl_wr), .wb_dsp_control(wb_ctl),
		.dsp_control_in(ctl));
	function automatic logic [16:0] lane(input logic [15:0] x, input logic [15:0] y,
		input logic sat);
		logic signed [31:0] p;
		logic               ov;
		p = $signed(x) * $signed(y);
		ov = (p > 32'sh7fff) || (p < -32'sh8000);
		if (sat && ov)
			return {1'b1, p[31] ? 16'h8000 : 16'h7fff};
		return {ov, p[15:0]};
	endfunction : lane
	function automatic logic [32:0] frac(input logic [15:0] x, input logic [15:0] y);
		logic signed [31:0] p;
		p = $signed(x) * $signed(y);
		if (x == 16'h8000 && y == 16'h8000)
			return {1'b1, 32'h7fffffff};
		return {1'b0, p[30:0], 1'b0};
	endfunction : frac
	task automatic issue(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b,
		input logic [1:0] pe);
		logic [16:0] hi, lo;
		logic [32:0] f;
		@(posedge clock);
		issue_valid <= 1'b1;
		issue_op <= op;
		source_a <= a;
		source_b <= b;
		ext <= pe;
		acc_in <= {$random(seed), $random(seed)};
		hi = lane(a[31:16], b[31:16], op == 4'h2);
		lo = lane(a[15:0], b[15:0], op == 4'h2);
		f = (op == 4'h4) ? frac(a[31:16], b[31:16]) : frac(a[15:0], b[15:0]);
		if (!(op inside {4'h1, 4'h2, 4'h4, 4'h8}))
			return;
		if (!pe[1])
			exp_q.push_back({3'h2, 64'h0});
		else if (!pe[0])
			exp_q.push_back({3'h1, 64'h0});
		else if (op[3:2] != 2'h0)
		begin
			exp_ctl = exp_ctl | {10'h0, f[32], 21'h0};
			exp_q.push_back({3'h4, f[31:0], exp_ctl});
		end
		else
		begin
			exp_ctl = exp_ctl | {10'h0, hi[16] | lo[16], 21'h0};
			exp_q.push_back({3'h4, hi[15:0], lo[15:0], exp_ctl});
		end
	endtask : issue
	task automatic load_ctl(input logic [31:0] v);
		@(posedge clock);
		exp_ctl = v;
		issue_valid <= 1'b0;
		sw_write <= 1'b1;
		sw_data <= v;
		@(posedge clock);
		sw_write <= 1'b0;
	endtask : load_ctl
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_word
	task automatic cmp_kind(input logic [2:0] got, input logic [2:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: kind %h expected %h", $time, got, exp);
		end
	endtask : cmp_kind
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	task automatic finish_test(input string name);
		int k;
		k = 0;
		@(posedge clock);
		issue_valid <= 1'b0;
		while (exp_q.size() > 0 && k < 10)
		begin
			@(posedge clock);
			k++;
		end
		repeat (2) @(posedge clock);
		if (exp_q.size() > 0)
		begin
			n_mismatch++;
			summarize();
		end
		else
			$display("test %s done", name);
	endtask : finish_test
	always @(posedge clock)
	begin
		if (reset_n && (wb_valid | exc_r | exc_d) !== 1'b0)
		begin
			e = 67'h0;
			if (exp_q.size() > 0)
				e = exp_q.pop_front();
			cmp_kind({wb_valid, exc_r, exc_d}, e[66:64]);
			if (e[66])
			begin
				cmp_word(wb_dest, e[63:32]);
				cmp_word(wb_ctl, e[31:0]);
			end
		end
	end
	initial
	begin
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		load_ctl(32'h0);
		issue(4'h2, 32'h7fff0002, 32'h00020003, 2'h3);
		issue(4'h1, 32'h7fff0002, 32'h00020003, 2'h3);
		issue(4'h2, 32'h80000001, 32'h0002ffff, 2'h3);
		issue(4'h2, 32'h80008000, 32'h80008000, 2'h3);
		issue(4'h4, 32'h80001234, 32'h80005678, 2'h3);
		issue(4'h8, 32'h12348000, 32'h56788000, 2'h3);
		issue(4'h8, 32'h0000c000, 32'h00004000, 2'h3);
		issue(4'h4, 32'h40000000, 32'hc0000000, 2'h3);
		finish_test("corners");
		load_ctl(32'hffdfffff);
		issue(4'h1, 32'h00030004, 32'h00050006, 2'h3);
		issue(4'h1, 32'h01000100, 32'h01000100, 2'h3);
		issue(4'h4, 32'h00010000, 32'h00010000, 2'h3);
		finish_test("sticky flag");
		load_ctl(32'h0);
		issue(4'h2, 32'h7fff7fff, 32'h7fff7fff, 2'h1);
		issue(4'h4, 32'h80008000, 32'h80008000, 2'h0);
		issue(4'h8, 32'h80008000, 32'h80008000, 2'h2);
		issue(4'h3, 32'h7fff7fff, 32'h7fff7fff, 2'h3);
		issue(4'h0, 32'h7fff7fff, 32'h7fff7fff, 2'h3);
		issue(4'h1, 32'h7fff7fff, 32'h7fff7fff, 2'h3);
		finish_test("exceptions");
		for (i = 0; i < 300; i++)
			issue(4'h1 << ($random(seed) & 3), $random(seed), $random(seed), 2'h3);
		finish_test("random");
		summarize();
	end
endmodule : tb_halfword_vector_multiplier
